/* File: motor_pwm_pkg.sv */
// constants, types and register map of the motor pwm controller
package motor_pwm_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PERIOD_NS = 50_000;
  localparam int OSC_DIV       = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ACT_TICKS     = 2048;
  localparam int WIN_TICKS     = 8192;
  localparam int DIS_TICKS     = 65536;
  localparam int WIN_SEQ       = 8;

  // transfer function, centivolts
  localparam int EFF_BASE_CV  = 288;
  localparam int AUTO_GAIN_CV = 1312;
  localparam int MAN_GAIN_CV  = 656;
  localparam int MAN_SCALE    = 100;
  localparam int DUTY_FULL    = 256;
  localparam int CAP_DOWN     = 16;
  localparam int MEAS_W       = 11;

  // register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MEAS   = 4'h8;
  localparam logic [3:0] ADDR_DUTY   = 4'hc;
  localparam int         CTRL_RUN_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_RUN   = 2'b01,
    ST_FAULT = 2'b10
  } state_t;

  typedef struct packed {
    logic [3:0] win_cnt;
    logic       attempt;
    logic       disabled;
    logic       cur_fault;
    logic       ov_fault;
    logic       active;
    logic       manual;
    state_t     state;
  } status_t;

endpackage

/* File: duty_divider.sv */
// serial divider producing the saturated gate duty
module duty_divider #(
  parameter int W  = 32,
  parameter int QW = 9
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // request
  input  wire logic          start,
  input  wire logic [W-1:0]  num,
  input  wire logic [W-1:0]  den,
  // answer
  output logic               busy,
  output logic               done,
  output logic [QW-1:0]      quot
);

  localparam int CW = $clog2(W + 1);
  localparam logic [W-1:0] LIMIT = W'(motor_pwm_pkg::DUTY_FULL);

  logic [W:0]    rem_reg;
  logic [W-1:0]  num_reg;
  logic [W-1:0]  den_reg;
  logic [W-1:0]  q_reg;
  logic [CW-1:0] cnt_reg;
  logic          busy_reg;
  logic          done_reg;
  logic [QW-1:0] quot_reg;

  wire [W:0]   rem_sh  = {rem_reg[W-1:0], num_reg[W-1]};
  wire         ge      = rem_sh >= {1'b0, den_reg};
  wire [W:0]   rem_nx  = ge ? rem_sh - {1'b0, den_reg} : rem_sh;
  wire [W-1:0] q_nx    = {q_reg[W-2:0], ge};
  wire         last    = cnt_reg == CW'(W - 1);
  // full duty is the ceiling, zero divisor saturates
  wire [QW-1:0] q_sat  = (q_nx > LIMIT) ? QW'(motor_pwm_pkg::DUTY_FULL) : q_nx[QW-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_reg  <= '0;
      num_reg  <= '0;
      den_reg  <= '0;
      q_reg    <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      quot_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        rem_reg  <= '0;
        num_reg  <= num;
        den_reg  <= den;
        q_reg    <= '0;
        cnt_reg  <= '0;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        rem_reg <= rem_nx;
        num_reg <= {num_reg[W-2:0], 1'b0};
        q_reg   <= q_nx;
        cnt_reg <= cnt_reg + CW'(1);
        if (last) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          quot_reg <= q_sat;
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign quot = quot_reg;

endmodule

/* File: motor_pwm_ctrl.sv */
// motor pwm controller: command decode, state machine, gate pwm, axi registers
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
module motor_pwm_ctrl #(
  parameter int OSC_DIV   = motor_pwm_pkg::OSC_DIV,
  parameter int ACT_TICKS = motor_pwm_pkg::ACT_TICKS,
  parameter int WIN_TICKS = motor_pwm_pkg::WIN_TICKS,
  parameter int DIS_TICKS = motor_pwm_pkg::DIS_TICKS
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // command and sense pins
  input  wire logic        AUTO_IN,
  input  wire logic        MAN_HIGH_IN,
  input  wire logic        MAN_OPEN_IN,
  input  wire logic [7:0]  MAN_DIFF_CV,
  input  wire logic [15:0] VBAT_CV,
  input  wire logic        OV_FLAG_IN,
  input  wire logic        UV_FLAG_IN,
  input  wire logic        CURRENT_SENSE_IN,
  // driver outputs
  output logic             GATE_DRIVE_OUT,
  output logic             SWITCHED_REFERENCE_OUT,
  output logic             INT_PULL_LOW,
  output logic             AUTO_PULLUP_EN,
  // axi4-lite write
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  localparam int DW = $clog2(OSC_DIV + 1);
  localparam int AW = $clog2(ACT_TICKS + 1);
  localparam int WW = $clog2(WIN_TICKS + 1);
  localparam int XW = $clog2(DIS_TICKS + 1);
  localparam int MW = motor_pwm_pkg::MEAS_W;
  localparam int PW = 30;

  if (OSC_DIV < 2 || ACT_TICKS < 2 || WIN_TICKS < 2 || DIS_TICKS < 2) begin : g_chk
    $error("tick counts must be at least two");
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  wire [PW-1:0] pin_raw = {AUTO_IN, MAN_HIGH_IN, MAN_OPEN_IN, OV_FLAG_IN,
                           UV_FLAG_IN, CURRENT_SENSE_IN, MAN_DIFF_CV, VBAT_CV};
  logic [PW-1:0] meta_reg;
  logic [PW-1:0] sync_reg;
  logic          auto_prev_reg;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      meta_reg      <= {1'b1, {(PW-1){1'b0}}};
      sync_reg      <= {1'b1, {(PW-1){1'b0}}};
      auto_prev_reg <= 1'b1;
    end else begin
      meta_reg      <= pin_raw;
      sync_reg      <= meta_reg;
      auto_prev_reg <= sync_reg[29];
    end
  end

  wire        auto_s  = sync_reg[29];
  wire        manual  = sync_reg[28];
  wire        mopen_s = sync_reg[27];
  wire        ov_s    = sync_reg[26];
  wire        uv_s    = sync_reg[25];
  wire        cs_s    = sync_reg[24];
  wire [7:0]  mdiff_s = sync_reg[23:16];
  wire [15:0] vbat_s  = sync_reg[15:0];
  wire        a_edge  = auto_s != auto_prev_reg;
  wire        a_fall  = auto_prev_reg && !auto_s;
  wire        a_rise  = auto_s && !auto_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator tick and command watchdog

  logic [DW-1:0] tick_cnt_reg;
  logic [AW-1:0] act_cnt_reg;
  wire           tick = tick_cnt_reg == DW'(OSC_DIV - 1);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + DW'(1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      act_cnt_reg <= AW'(ACT_TICKS);
    end else if (a_edge) begin
      act_cnt_reg <= '0;
    end else if (tick && act_cnt_reg != AW'(ACT_TICKS)) begin
      act_cnt_reg <= act_cnt_reg + AW'(1);
    end
  end

  wire cmd_active = act_cnt_reg != AW'(ACT_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // command duty measurement, rising edge to rising edge

  logic [MW-1:0] per_cnt_reg;
  logic [MW-1:0] hi_cnt_reg;
  logic [MW-1:0] per_reg;
  logic [MW-1:0] low_reg;
  wire  [MW-1:0] sat = {MW{1'b1}};

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      per_cnt_reg <= '0;
      hi_cnt_reg  <= '0;
      per_reg     <= '0;
      low_reg     <= '0;
    end else if (a_rise) begin
      per_reg     <= per_cnt_reg;
      low_reg     <= per_cnt_reg - hi_cnt_reg;
      per_cnt_reg <= MW'(tick);
      hi_cnt_reg  <= MW'(tick);
    end else if (tick && per_cnt_reg != sat) begin
      per_cnt_reg <= per_cnt_reg + MW'(1);
      hi_cnt_reg  <= hi_cnt_reg + MW'(auto_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty = (base + gain * fraction) * 256 / vbat

  wire [31:0] op_p = manual ? 32'(motor_pwm_pkg::MAN_SCALE) : 32'(per_reg);
  wire [31:0] op_k = manual ? 32'(motor_pwm_pkg::MAN_GAIN_CV)
                            : 32'(motor_pwm_pkg::AUTO_GAIN_CV);
  wire [31:0] op_l = manual ? 32'(mdiff_s) : 32'(low_reg);
  wire [31:0] div_num = (32'(motor_pwm_pkg::EFF_BASE_CV) * op_p + op_k * op_l) << 8;
  wire [31:0] div_den = op_p * 32'(vbat_s);
  logic       div_busy;
  logic       div_done;
  logic [8:0] div_q;
  logic [8:0] duty_reg;

  duty_divider #(
    .W  (32),
    .QW (9)
  ) u_div (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .start (tick),
    .num   (div_num),
    .den   (div_den),
    .busy  (div_busy),
    .done  (div_done),
    .quot  (div_q)
  );

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      duty_reg <= '0;
    end else if (div_done) begin
      duty_reg <= div_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current limit cap and fault supervisor

  motor_pwm_pkg::state_t state_reg;
  motor_pwm_pkg::state_t state_next;
  logic          gate_reg;
  logic          lim_seen_reg;
  logic [8:0]    cap_reg;
  logic [WW-1:0] win_tick_reg;
  logic          win_flag_reg;
  logic [3:0]    win_cnt_reg;
  logic          attempt_reg;
  logic          dis_reg;
  logic [XW-1:0] dis_cnt_reg;
  logic          cur_fault_reg;

  wire run     = state_reg == motor_pwm_pkg::ST_RUN;
  wire asleep  = state_reg == motor_pwm_pkg::ST_SLEEP;
  wire lim     = cs_s && gate_reg;
  wire win_end = tick && win_tick_reg == WW'(WIN_TICKS - 1);
  wire seq_end = win_cnt_reg == 4'(motor_pwm_pkg::WIN_SEQ - 1);
  wire win_hit = win_flag_reg || lim;
  wire dis_end = tick && dis_cnt_reg == XW'(DIS_TICKS - 1);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lim_seen_reg <= 1'b0;
      cap_reg      <= '0;
    end else if (!run || dis_reg) begin
      lim_seen_reg <= 1'b0;
      cap_reg      <= '0;
    end else if (tick) begin
      lim_seen_reg <= lim;
      if (lim_seen_reg || lim) begin
        cap_reg <= (cap_reg > 9'(motor_pwm_pkg::CAP_DOWN))
                   ? cap_reg - 9'(motor_pwm_pkg::CAP_DOWN) : '0;
      end else if (cap_reg != 9'(motor_pwm_pkg::DUTY_FULL)) begin
        cap_reg <= cap_reg + 9'h1;
      end
    end else if (lim) begin
      lim_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      win_tick_reg <= '0;
      win_flag_reg <= 1'b0;
      win_cnt_reg  <= '0;
      attempt_reg  <= 1'b0;
      dis_reg      <= 1'b0;
      dis_cnt_reg  <= '0;
    end else if (asleep) begin
      win_tick_reg <= '0;
      win_flag_reg <= 1'b0;
      win_cnt_reg  <= '0;
      attempt_reg  <= 1'b0;
      dis_reg      <= 1'b0;
      dis_cnt_reg  <= '0;
    end else if (dis_reg) begin
      dis_cnt_reg <= tick ? dis_cnt_reg + XW'(1) : dis_cnt_reg;
      dis_reg     <= !dis_end;
    end else if (run) begin
      win_flag_reg <= win_end ? 1'b0 : win_hit;
      if (tick) begin
        win_tick_reg <= win_end ? '0 : win_tick_reg + WW'(1);
      end
      if (win_end && win_hit && seq_end) begin
        win_cnt_reg  <= '0;
        attempt_reg  <= 1'b1;
        dis_reg      <= !attempt_reg;
        dis_cnt_reg  <= '0;
      end else if (win_end && win_hit) begin
        win_cnt_reg <= win_cnt_reg + 4'h1;
      end else if (win_end) begin
        win_cnt_reg <= '0;
        attempt_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cur_fault_reg <= 1'b0;
    end else if (asleep) begin
      cur_fault_reg <= 1'b0;
    end else if (run && !dis_reg && win_end && win_hit && seq_end && attempt_reg) begin
      cur_fault_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep, run and fault states

  logic [31:0] ctrl_reg;
  wire run_en = ctrl_reg[motor_pwm_pkg::CTRL_RUN_EN];
  wire sleep_cond = uv_s || !run_en || (manual ? mopen_s : !cmd_active);
  wire wake = !uv_s && run_en && (manual ? !mopen_s : a_fall);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      motor_pwm_pkg::ST_SLEEP: begin
        if (wake) state_next = motor_pwm_pkg::ST_RUN;
      end
      motor_pwm_pkg::ST_RUN: begin
        if (sleep_cond) state_next = motor_pwm_pkg::ST_SLEEP;
        else if (ov_s || cur_fault_reg) state_next = motor_pwm_pkg::ST_FAULT;
      end
      motor_pwm_pkg::ST_FAULT: begin
        if (sleep_cond) state_next = motor_pwm_pkg::ST_SLEEP;
        else if (!ov_s && !cur_fault_reg) state_next = motor_pwm_pkg::ST_RUN;
      end
      default: state_next = motor_pwm_pkg::ST_SLEEP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate pwm and driver outputs

  wire [8:0]    duty_eff = (duty_reg < cap_reg) ? duty_reg : cap_reg;
  logic [DW:0]  hi_len_reg;
  logic         ref_reg;
  logic         intpl_reg;
  logic         pullup_reg;
  wire  [DW+8:0] hi_prod = (DW+9)'(duty_eff) * (DW+9)'(OSC_DIV);
  wire          gate_next = run && !dis_reg && ({1'b0, tick_cnt_reg} < hi_len_reg);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_reg  <= motor_pwm_pkg::ST_SLEEP;
      hi_len_reg <= '0;
      gate_reg   <= 1'b0;
      ref_reg    <= 1'b0;
      intpl_reg  <= 1'b1;
      pullup_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      hi_len_reg <= tick ? (DW+1)'(hi_prod >> 8) : hi_len_reg;
      gate_reg   <= gate_next;
      ref_reg    <= run;
      intpl_reg  <= !run || dis_reg || lim || ov_s;
      pullup_reg <= !manual && !asleep;
    end
  end

  assign GATE_DRIVE_OUT         = gate_reg;
  assign SWITCHED_REFERENCE_OUT = ref_reg;
  assign INT_PULL_LOW           = intpl_reg;
  assign AUTO_PULLUP_EN         = pullup_reg;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic        aw_have_reg;
  logic        w_have_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  motor_pwm_pkg::status_t status;
  assign status = '{win_cnt: win_cnt_reg, attempt: attempt_reg, disabled: dis_reg,
                    cur_fault: cur_fault_reg,
                    ov_fault: state_reg == motor_pwm_pkg::ST_FAULT && ov_s,
                    active: cmd_active, manual: manual, state: state_reg};

  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take  = S_AXI_WVALID && S_AXI_WREADY;
  wire wr_go   = aw_have_reg && w_have_reg && !bvalid_reg;
  wire wr_ctrl = aw_addr_reg == motor_pwm_pkg::ADDR_CTRL;
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire rd_ok   = S_AXI_ARADDR == motor_pwm_pkg::ADDR_CTRL
              || S_AXI_ARADDR == motor_pwm_pkg::ADDR_STATUS
              || S_AXI_ARADDR == motor_pwm_pkg::ADDR_MEAS
              || S_AXI_ARADDR == motor_pwm_pkg::ADDR_DUTY;
  wire [31:0] rd_mux =
      (S_AXI_ARADDR == motor_pwm_pkg::ADDR_CTRL)   ? ctrl_reg :
      (S_AXI_ARADDR == motor_pwm_pkg::ADDR_STATUS) ? 32'(status) :
      (S_AXI_ARADDR == motor_pwm_pkg::ADDR_MEAS)   ? {5'h0, per_reg, 5'h0, low_reg} :
      (S_AXI_ARADDR == motor_pwm_pkg::ADDR_DUTY)   ? {7'h0, cap_reg, 7'h0, duty_reg} :
      32'h0;
  wire [31:0] strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  assign S_AXI_AWREADY = !aw_have_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_have_reg && !bvalid_reg;
  assign S_AXI_ARREADY = !rvalid_reg;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= motor_pwm_pkg::RESP_OKAY;
      ctrl_reg    <= motor_pwm_pkg::CTRL_RESET;
    end else begin
      if (aw_take) aw_have_reg <= 1'b1;
      if (aw_take) aw_addr_reg <= S_AXI_AWADDR;
      if (w_take) w_have_reg <= 1'b1;
      if (w_take) w_data_reg <= S_AXI_WDATA;
      if (w_take) w_strb_reg <= S_AXI_WSTRB;
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ctrl || aw_addr_reg == motor_pwm_pkg::ADDR_STATUS
                    || aw_addr_reg == motor_pwm_pkg::ADDR_MEAS
                    || aw_addr_reg == motor_pwm_pkg::ADDR_DUTY
                     ? motor_pwm_pkg::RESP_OKAY : motor_pwm_pkg::RESP_DECERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (wr_go && wr_ctrl) begin
        ctrl_reg <= ((ctrl_reg & ~strb_mask) | (w_data_reg & strb_mask)) & 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= motor_pwm_pkg::RESP_OKAY;
      rdata_reg  <= '0;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_ok ? motor_pwm_pkg::RESP_OKAY : motor_pwm_pkg::RESP_DECERR;
      rdata_reg  <= rd_mux;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP  = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP  = rresp_reg;
  assign S_AXI_RDATA  = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sleep_gate_low_a: assert property (
    asleep ##1 asleep |-> !GATE_DRIVE_OUT) else $error("gate high while asleep");
  idle_line_sleep_a: assert property (
    run && !manual && !cmd_active |=> asleep) else $error("idle line did not sleep");
  fall_wakes_a: assert property (
    asleep && !manual && a_fall && !uv_s && run_en |=> run) else $error("edge did not wake");
  fault_cause_a: assert property (
    !$stable(state_reg) && state_reg == motor_pwm_pkg::ST_FAULT
      |-> $past(ov_s) || $past(cur_fault_reg)) else $error("fault without cause");
  ov_return_a: assert property (
    state_reg == motor_pwm_pkg::ST_FAULT && !ov_s && !cur_fault_reg && !sleep_cond
      |=> run) else $error("no return to run");
  ref_switch_a: assert property (
    ##1 SWITCHED_REFERENCE_OUT == $past(run)) else $error("reference switch wrong");
  disable_gate_a: assert property (
    dis_reg ##1 dis_reg |-> !GATE_DRIVE_OUT) else $error("gate during disable");
  clean_window_a: assert property (
    run && !dis_reg && win_end && !win_hit |=> win_cnt_reg == 4'h0 && !attempt_reg)
    else $error("window latches not cleared");
  uv_sleep_a: assert property (
    !asleep && uv_s |=> asleep) else $error("undervoltage did not sleep");

  wake_run_c: cover property (asleep ##1 run);
  full_duty_c: cover property (run && gate_reg [*8]);
  cur_fault_c: cover property ($rose(cur_fault_reg));
  ov_fault_c: cover property (run ##1 state_reg == motor_pwm_pkg::ST_FAULT ##[1:20] run);

endmodule

/* File: cmd_source.sv */
// speed command source: open-collector pwm on the auto line
module cmd_source #(
  parameter int PERIOD = 40,
  parameter int LOW    = 10
) (
  // clock and control
  input  wire logic clk,
  input  wire logic en,
  // command line
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= (cnt + 1) % PERIOD;
    line <= !(en && cnt < LOW);
  end
endmodule

/* File: motor_pwm_ctrl_bench.sv */
// self-checking bench of the motor pwm controller
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module motor_pwm_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic mh, mo, ov, uv, cmd;
    motor_pwm_pkg::state_t st;
    logic rf;
  } row_t;
  // man high, man open, ov, uv, cmd | state, reference
  row_t rows [8] = '{8'b00001_01_1, 8'b00101_10_0, 8'b00001_01_1,
    8'b00011_00_0, 8'b00001_01_1, 8'b00000_00_0, 8'b10000_01_1, 8'b11000_00_0};
  logic clk = 0, rst_n = 0, mh = 0, mo = 0, ov = 0, uv = 0, cmd = 0, cs = 0;
  logic [7:0]  mdiff = 8'h64;
  logic [15:0] vbat = 16'h04b0;
  logic [3:0]  strb = 4'hf;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [3:0]  awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0]  resp;
  wire         awr, wrd, bv, arr, rv, gate, switched_reference_out, ipl, pu, line;
  wire [1:0]   br, rr;
  wire [31:0]  rdata;
  int          n_errors = 0, n_compared = 0;
  always #50 clk = ~clk;
  cmd_source u_src (.clk(clk), .en(cmd), .line(line));
  motor_pwm_ctrl #(.OSC_DIV(4), .ACT_TICKS(16), .WIN_TICKS(16), .DIS_TICKS(32)) u_dut (
    .CLK_SYS(clk), .RST_N(rst_n), .AUTO_IN(line), .MAN_HIGH_IN(mh), .MAN_OPEN_IN(mo),
    .MAN_DIFF_CV(mdiff), .VBAT_CV(vbat), .OV_FLAG_IN(ov), .UV_FLAG_IN(uv),
    .CURRENT_SENSE_IN(cs), .GATE_DRIVE_OUT(gate), .SWITCHED_REFERENCE_OUT(switched_reference_out),
    .INT_PULL_LOW(ipl), .AUTO_PULLUP_EN(pu),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic t;
    t = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!t) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) begin
        t = 1'b1;
        resp = br;
      end
    end
  endtask
  task automatic rdr(input logic [3:0] a);
    logic t;
    t = 1'b0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    while (!t) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        t = 1'b1;
        rd = rdata;
        resp = rr;
      end
    end
  endtask
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      {mh, mo, ov, uv, cmd} <= rows[i][7:3];
      repeat (300) @(posedge clk);
      rdr(motor_pwm_pkg::ADDR_STATUS);
      `CHK(rd[1:0], rows[i].st)
      `CHK(switched_reference_out, rows[i].rf)
      `CHK(pu, !rows[i].mh && rows[i].st != motor_pwm_pkg::ST_SLEEP)
      `CHK(ipl, rows[i].st != motor_pwm_pkg::ST_RUN)
      if (rows[i].st == motor_pwm_pkg::ST_SLEEP) `CHK(gate, 1'b0)
      else `CHK(rd[2], rows[i].mh)
    end
    // run enable cleared holds sleep against a live command
    {mh, mo, cmd} <= 3'b001;
    wr(motor_pwm_pkg::ADDR_CTRL, 32'h0);
    `CHK(resp, motor_pwm_pkg::RESP_OKAY)
    repeat (300) @(posedge clk);
    `CHK(gate, 1'b0)
    rdr(motor_pwm_pkg::ADDR_STATUS);
    `CHK(rd[1:0], motor_pwm_pkg::ST_SLEEP)
    wr(motor_pwm_pkg::ADDR_CTRL, motor_pwm_pkg::CTRL_RESET);
    repeat (300) @(posedge clk);
    rdr(motor_pwm_pkg::ADDR_STATUS);
    `CHK(rd[1:0], motor_pwm_pkg::ST_RUN)
    // command period of 40 clocks is ten oscillator ticks
    rdr(motor_pwm_pkg::ADDR_MEAS);
    `CHK(rd[26:16], 11'h00a)
    rdr(4'h2);
    `CHK(resp, motor_pwm_pkg::RESP_DECERR)
    // second reset in mid-run
    cmd <= 1'b0;
    rst_n <= 1'b0;
    @(posedge clk);
    `CHK({gate, switched_reference_out, ipl}, 3'b001)
    rst_n <= 1'b1;
    rdr(motor_pwm_pkg::ADDR_CTRL);
    `CHK(rd, motor_pwm_pkg::CTRL_RESET)
    rdr(motor_pwm_pkg::ADDR_STATUS);
    `CHK({rd[11:4], rd[1:0]}, 10'h000)
    // write without the low byte strobe leaves run enable set
    strb <= 4'he;
    wr(motor_pwm_pkg::ADDR_CTRL, 32'h0);
    strb <= 4'hf;
    rdr(motor_pwm_pkg::ADDR_CTRL);
    `CHK(rd, motor_pwm_pkg::CTRL_RESET)
    // manual command, duty follows 2.88 V plus 6.56 times 1.00 V over battery
    {mh, mo} <= 2'b10;
    repeat (300) @(posedge clk);
    rdr(motor_pwm_pkg::ADDR_DUTY);
    `CHK(rd[8:0], 9'h0c9)
    vbat <= 16'h0640;
    repeat (100) @(posedge clk);
    rdr(motor_pwm_pkg::ADDR_DUTY);
    `CHK(rd[8:0], 9'h097)
    vbat <= 16'h0320;
    repeat (1200) @(posedge clk);
    rdr(motor_pwm_pkg::ADDR_DUTY);
    `CHK(rd, {7'h0, 9'h100, 7'h0, 9'h100})
    repeat (8) begin
      @(posedge clk);
      `CHK(gate, 1'b1)
    end
    // sense above limit while gate is high pulls the cap down
    cs <= 1'b1;
    repeat (40) @(posedge clk);
    rdr(motor_pwm_pkg::ADDR_DUTY);
    `CHK(rd[24:16] < 9'h100, 1'b1)
    cs <= 1'b0;
    close_out;
  end
endmodule
